// *** verilog/mwx_pkg.sv ***
package mwx_pkg;

  // ****************************************
  // word geometry
  // ****************************************
  localparam int WORD_BITS    = 16;
  localparam int SCAN_WORDS   = 8;
  localparam int RESP_SLOTS   = 4;
  localparam int REGION_DEPTH = 16;

  // ****************************************
  // controller word 1 fields
  // ****************************************
  localparam int OUT_TOGGLE_POS  = 15;
  localparam int OUT_RESTART_POS = 14;
  localparam int OUT_RUN_POS     = 13;
  localparam int OUT_AXIS_HI     = 9;
  localparam int OUT_AXIS_LO     = 8;
  localparam int OUT_CMD_HI      = 7;
  localparam int OUT_CMD_LO      = 0;

  // ****************************************
  // status word 1 fields
  // ****************************************
  localparam int IN_TOGGLE_POS    = 15;
  localparam int IN_MODULE_OK_POS = 14;
  localparam int IN_A_PULSING_POS = 13;
  localparam int IN_A_STANDBY_POS = 12;
  localparam int IN_A_FAULT_POS   = 11;
  localparam int IN_B_PULSING_POS = 10;
  localparam int IN_B_STANDBY_POS = 9;
  localparam int IN_B_FAULT_POS   = 8;

  // ****************************************
  // axis selection and command codes
  // ****************************************
  localparam logic [1:0] AXIS_A    = 2'h1;
  localparam logic [1:0] AXIS_B    = 2'h2;
  localparam logic [1:0] AXIS_BOTH = 2'h3;

  localparam logic [7:0] CMD_CLEAR_ALL    = 8'h01;
  localparam logic [7:0] CMD_CLEAR_SYSTEM = 8'h02;
  localparam logic [7:0] CMD_CLEAR_AXIS   = 8'h03;

  // ****************************************
  // response layouts and handshake states
  // ****************************************
  typedef enum logic [1:0] {
    MWX_RESP_NONE   = 2'h0,
    MWX_RESP_SHORT  = 2'h1,
    MWX_RESP_LONG   = 2'h2,
    MWX_RESP_NOAXIS = 2'h3
  } mwx_resp_type;

  typedef enum logic [2:0] {
    MWX_IDLE  = 3'b001,
    MWX_WAIT  = 3'b010,
    MWX_FETCH = 3'b100
  } mwx_state_type;

  localparam logic [15:0] ZERO_WORD = 16'h0000;

endpackage

// *** verilog/mwx_resp_mem.sv ***
module mwx_resp_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic                     clock,
  input  wire logic                     writeEnable,
  input  wire logic [$clog2(DEPTH)-1:0] writeAddr,
  input  wire logic [WIDTH-1:0]         writeData,
  input  wire logic [$clog2(DEPTH)-1:0] readAddr,
  output logic      [WIDTH-1:0]         readData
);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("mwx_resp_mem: unsupported geometry");
    end
  end

  logic [WIDTH-1:0] store [DEPTH];

  // no reset on purpose: contents are meaningless until the engine loads them
  always_ff @(posedge clock) begin
    if (writeEnable) begin
      store[writeAddr] <= writeData;
    end
    readData <= store[readAddr];
  end

endmodule // mwx_resp_mem

// *** verilog/mwx_host_exchange.sv ***
// What this block does
// [RULE1] eight controller words in, eight status out
// [RULE2] controller refreshes both word sets every scan
// [RULE3] long transfers span several toggle handshakes
// [RULE4] word 1: toggle, command, axis, run
// [RULE5] restart bit falling edge reinitialises handshake
// [RULE6] run bit low halts pulse output
// [RULE7] words 2 to 8 carry command payload
// [RULE8] short writes: A in 2-3, B 4-5
// [RULE9] long axis writes use second layout
// [RULE10] axisless writes packed from word 2, counted
// [RULE11] status toggle follows controller toggle after work
// [RULE12] controller toggle announces new command
// [RULE13] axis A fault bit 11, B bit 8
// [RULE14] faults stick until explicit clear command
// [RULE15] status word 1 flag order, low byte system
// [RULE16] words 3-8 default until command asks otherwise
// [RULE17] short reads: A in 5-6, B 7-8
// [RULE18] short reads always carry both error codes
// [RULE19] dual-axis long reads: B before A
// [RULE20] axisless reads packed from word 5, counted
// [RULE21] clear all, system, or addressed axis faults
// [RULE22] serial commands on both axes start A first
// [RULE23] controller holds payload until toggles match
module mwx_host_exchange #(
  parameter int REGION_DEPTH = mwx_pkg::REGION_DEPTH
) (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic [15:0]              outWord1,
  input  wire logic [15:0]              outWord2,
  input  wire logic [15:0]              outWord3,
  input  wire logic [15:0]              outWord4,
  input  wire logic [15:0]              outWord5,
  input  wire logic [15:0]              outWord6,
  input  wire logic [15:0]              outWord7,
  input  wire logic [15:0]              outWord8,
  input  wire logic                     axisPulsingA,
  input  wire logic                     axisStandbyA,
  input  wire logic                     axisPulsingB,
  input  wire logic                     axisStandbyB,
  input  wire logic                     faultEventA,
  input  wire logic                     faultEventB,
  input  wire logic                     sysFaultEvent,
  input  wire logic                     moduleReady,
  input  wire logic [7:0]               systemByte,
  input  wire logic [15:0]              extInputs,
  input  wire logic [5:0][15:0]         defaultWords,
  input  wire logic                     cmdSerial,
  input  wire logic                     cmdDone,
  input  wire logic                     cmdMore,
  input  wire logic [1:0]               respKind,
  input  wire logic [4:0]               respLenA,
  input  wire logic [4:0]               respLenB,
  input  wire logic [15:0]              errCodeA,
  input  wire logic [15:0]              errCodeB,
  input  wire logic                     loadValid,
  input  wire logic [4:0]               loadAddr,
  input  wire logic [15:0]              loadData,
  output logic      [15:0]              inWord1,
  output logic      [15:0]              inWord2,
  output logic      [15:0]              inWord3,
  output logic      [15:0]              inWord4,
  output logic      [15:0]              inWord5,
  output logic      [15:0]              inWord6,
  output logic      [15:0]              inWord7,
  output logic      [15:0]              inWord8,
  output logic                          pulseEnable,
  output logic                          cmdValid,
  output logic                          cmdContinue,
  output logic      [7:0]               cmdCode,
  output logic      [1:0]               cmdAxis,
  output logic      [6:0][15:0]         cmdPayload
);

  initial begin
    if (REGION_DEPTH != 16) begin
      $error("mwx_host_exchange: response regions must hold 16 words");
    end
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mwx_pkg::mwx_state_type state;
    logic                   transferToggle;
    logic                   toggleSeen;
    logic                   restartPrev;
    logic                   runEnable;
    logic                   faultA;
    logic                   faultB;
    logic                   sysFault;
    logic                   cmdValid;
    logic                   cmdContinue;
    logic                   moreWrite;
    logic [7:0]             cmdCode;
    logic [1:0]             cmdAxis;
    logic                   pendingB;
    logic [1:0]             kind;
    logic                   showDefault;
    logic                   countDue;
    logic                   half;
    logic [1:0]             slot;
    logic [4:0]             lenA;
    logic [4:0]             lenB;
    logic [4:0]             remA;
    logic [4:0]             remB;
    logic [15:0]            word1;
    logic [15:0]            word2;
    logic [15:0]            word3;
    logic [15:0]            word4;
    logic [3:0][15:0]       resp;
    logic [6:0][15:0]       payload;
  } mwx_regs_type;

  mwx_regs_type r;
  mwx_regs_type next_r;

  logic [4:0]  readAddr;
  logic [15:0] readData;
  logic [15:0] fetchWord;
  logic        takeA;
  logic        takeB;
  logic        useCount;
  logic [4:0]  idxA;
  logic [4:0]  idxB;
  logic        outToggle;
  logic [1:0]  outAxis;
  logic [7:0]  outCode;
  logic        restartFall;
  logic        clearA;
  logic        clearB;
  logic        clearSys;

  mwx_resp_mem #(
    .WIDTH(mwx_pkg::WORD_BITS),
    .DEPTH(2 * REGION_DEPTH)
  ) respMem (
    .clock      (clock),
    .writeEnable(loadValid),
    .writeAddr  (loadAddr),
    .writeData  (loadData),
    .readAddr   (readAddr),
    .readData   (readData)
  );

  // ****************************************
  // word 1 decode and word selection for a response slot
  // ****************************************
  always_comb begin
    outToggle   = outWord1[mwx_pkg::OUT_TOGGLE_POS];
    outAxis     = outWord1[mwx_pkg::OUT_AXIS_HI:mwx_pkg::OUT_AXIS_LO];
    outCode     = outWord1[mwx_pkg::OUT_CMD_HI:mwx_pkg::OUT_CMD_LO];
    restartFall = r.restartPrev && !outWord1[mwx_pkg::OUT_RESTART_POS]; // RULE5
    idxA        = r.lenA - r.remA;
    idxB        = r.lenB - r.remB;
    useCount    = r.countDue && (r.slot == 2'h0); // RULE20
    takeB       = 1'b0;
    takeA       = 1'b0;
    readAddr    = 5'h00;
    if (r.kind == mwx_pkg::MWX_RESP_SHORT) begin
      readAddr = {r.slot[1], 3'h0, r.slot[0]}; // RULE17
    end else if (!useCount && r.remB != 5'h00) begin
      takeB    = 1'b1; // RULE19
      readAddr = {1'b1, idxB[3:0]};
    end else if (!useCount && r.remA != 5'h00) begin
      takeA    = 1'b1;
      readAddr = {1'b0, idxA[3:0]}; // RULE20
    end
    if (useCount) begin
      fetchWord = {11'h000, r.lenA};
    end else if (r.kind == mwx_pkg::MWX_RESP_SHORT || takeA || takeB) begin
      fetchWord = readData;
    end else begin
      fetchWord = mwx_pkg::ZERO_WORD;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_r          = r;
    next_r.cmdValid = 1'b0;
    clearA          = 1'b0;
    clearB          = 1'b0;
    clearSys        = 1'b0;
    next_r.restartPrev = outWord1[mwx_pkg::OUT_RESTART_POS];
    next_r.runEnable   = outWord1[mwx_pkg::OUT_RUN_POS]; // RULE6
    next_r.word2       = extInputs;

    case (r.state)
      mwx_pkg::MWX_IDLE: begin
        // a toggle edge is one handshake; payload is held until we echo
        if (!outWord1[mwx_pkg::OUT_RESTART_POS] && outToggle != r.toggleSeen) begin // RULE12
          next_r.toggleSeen = outToggle;
          if (r.kind != mwx_pkg::MWX_RESP_NONE && (r.remA != 5'h00 || r.remB != 5'h00)) begin
            next_r.state = mwx_pkg::MWX_FETCH; // RULE3
            next_r.slot  = 2'h0;
            next_r.half  = 1'b0;
          end else begin
            next_r.state       = mwx_pkg::MWX_WAIT;
            next_r.cmdValid    = 1'b1;
            next_r.cmdContinue = r.moreWrite; // RULE3
            next_r.cmdCode     = outCode; // RULE4
            next_r.payload     = {outWord8, outWord7, outWord6, outWord5,
                                  outWord4, outWord3, outWord2}; // RULE7 RULE8 RULE9 RULE10
            next_r.cmdAxis     = outAxis;
            next_r.pendingB    = 1'b0;
            if (outAxis == mwx_pkg::AXIS_BOTH && cmdSerial) begin
              next_r.cmdAxis  = mwx_pkg::AXIS_A; // RULE22
              next_r.pendingB = 1'b1;
            end
            if (!r.moreWrite && !restartFall) begin
              clearA   = (outCode == mwx_pkg::CMD_CLEAR_ALL) ||
                         (outCode == mwx_pkg::CMD_CLEAR_AXIS && outAxis[0]); // RULE21
              clearB   = (outCode == mwx_pkg::CMD_CLEAR_ALL) ||
                         (outCode == mwx_pkg::CMD_CLEAR_AXIS && outAxis[1]);
              clearSys = (outCode == mwx_pkg::CMD_CLEAR_ALL) ||
                         (outCode == mwx_pkg::CMD_CLEAR_SYSTEM);
            end
          end
        end
      end
      mwx_pkg::MWX_WAIT: begin
        if (cmdDone && r.pendingB) begin
          next_r.cmdValid = 1'b1; // RULE22
          next_r.cmdAxis  = mwx_pkg::AXIS_B;
          next_r.pendingB = 1'b0;
        end else if (cmdDone) begin
          next_r.moreWrite = cmdMore;
          next_r.kind      = respKind;
          next_r.lenA      = respLenA;
          next_r.lenB      = respLenB;
          next_r.remA      = respLenA;
          next_r.remB      = respLenB;
          next_r.countDue  = respKind == mwx_pkg::MWX_RESP_NOAXIS;
          if (respKind == mwx_pkg::MWX_RESP_NONE) begin
            next_r.showDefault    = 1'b1; // RULE16
            next_r.state          = mwx_pkg::MWX_IDLE;
            next_r.transferToggle = r.toggleSeen; // RULE11
          end else begin
            next_r.showDefault = 1'b0; // RULE16
            next_r.state       = mwx_pkg::MWX_FETCH;
            next_r.slot        = 2'h0;
            next_r.half        = 1'b0;
          end
        end
      end
      mwx_pkg::MWX_FETCH: begin
        // two cycles a slot: address, then registered memory data
        next_r.half = !r.half;
        if (r.half) begin
          next_r.resp[r.slot] = fetchWord;
          next_r.word3        = errCodeA; // RULE18
          next_r.word4        = errCodeB; // RULE18
          if (useCount) begin
            next_r.countDue = 1'b0;
          end
          if (takeA && r.kind != mwx_pkg::MWX_RESP_SHORT) begin
            next_r.remA = r.remA - 5'h01;
          end
          if (takeB && r.kind != mwx_pkg::MWX_RESP_SHORT) begin
            next_r.remB = r.remB - 5'h01;
          end
          if (r.slot == 2'h3) begin
            next_r.state          = mwx_pkg::MWX_IDLE;
            next_r.transferToggle = r.toggleSeen; // RULE11
            if (r.kind == mwx_pkg::MWX_RESP_SHORT) begin
              next_r.remA = 5'h00;
              next_r.remB = 5'h00;
            end
          end else begin
            next_r.slot = r.slot + 2'h1;
          end
        end
      end
      default: begin
        next_r.state = mwx_pkg::MWX_IDLE;
      end
    endcase

    if (restartFall) begin
      next_r.state          = mwx_pkg::MWX_IDLE; // RULE5
      next_r.transferToggle = 1'b0;
      next_r.toggleSeen     = 1'b0;
      next_r.kind           = mwx_pkg::MWX_RESP_NONE;
      next_r.remA           = 5'h00;
      next_r.remB           = 5'h00;
      next_r.moreWrite      = 1'b0;
      next_r.pendingB       = 1'b0;
      next_r.cmdValid       = 1'b0;
    end

    // a new fault event in the clear cycle still wins
    next_r.faultA   = faultEventA || (r.faultA && !clearA); // RULE14
    next_r.faultB   = faultEventB || (r.faultB && !clearB); // RULE14
    next_r.sysFault = sysFaultEvent || (r.sysFault && !clearSys);

    next_r.word1 = {r.transferToggle, moduleReady && !r.sysFault,
                    axisPulsingA, axisStandbyA, r.faultA,
                    axisPulsingB, axisStandbyB, r.faultB, systemByte}; // RULE13 RULE15
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      r             <= '0;
      r.state       <= mwx_pkg::MWX_IDLE;
      r.showDefault <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign inWord1     = r.word1; // RULE1
  assign inWord2     = r.word2;
  assign inWord3     = r.showDefault ? defaultWords[0] : r.word3; // RULE16
  assign inWord4     = r.showDefault ? defaultWords[1] : r.word4;
  assign inWord5     = r.showDefault ? defaultWords[2] : r.resp[0];
  assign inWord6     = r.showDefault ? defaultWords[3] : r.resp[1];
  assign inWord7     = r.showDefault ? defaultWords[4] : r.resp[2];
  assign inWord8     = r.showDefault ? defaultWords[5] : r.resp[3];
  assign pulseEnable = r.runEnable; // RULE6
  assign cmdValid    = r.cmdValid;
  assign cmdContinue = r.cmdContinue;
  assign cmdCode     = r.cmdCode;
  assign cmdAxis     = r.cmdAxis;
  assign cmdPayload  = r.payload;

endmodule // mwx_host_exchange

// *** testbench/mwx_host_exchange_properties.sv ***
module mwx_host_exchange_properties (
  input wire logic             clock,
  input wire logic             reset,
  input wire logic [15:0]      outWord1,
  input wire logic [15:0]      outWord2,
  input wire logic [15:0]      outWord3,
  input wire logic [15:0]      outWord4,
  input wire logic [15:0]      outWord5,
  input wire logic [15:0]      outWord6,
  input wire logic [15:0]      outWord7,
  input wire logic [15:0]      outWord8,
  input wire logic             axisPulsingA,
  input wire logic             axisStandbyA,
  input wire logic             axisPulsingB,
  input wire logic             axisStandbyB,
  input wire logic             faultEventA,
  input wire logic             sysFaultEvent,
  input wire logic [7:0]       systemByte,
  input wire logic [15:0]      inWord1,
  input wire logic             pulseEnable,
  input wire logic             cmdValid,
  input wire logic [7:0]       cmdCode,
  input wire logic [6:0][15:0] cmdPayload
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ****************************************
  // handshake, command and status relations
  // ****************************************
  property p_echo_rise;
    $rose(inWord1[15]) |-> $past(outWord1[15]);
  endproperty
  a_echo_rise: assert property (p_echo_rise) else $error("echo rose without toggle");

  // a restart may pull the echo low while the toggle is still high
  property p_echo_fall;
    $fell(inWord1[15]) |-> !$past(outWord1[15]) || $past(outWord1[14], 2) || $past(outWord1[14], 3);
  endproperty
  a_echo_fall: assert property (p_echo_fall) else $error("echo fell without cause");

  property p_cmd_code;
    cmdValid |-> cmdCode == $past(outWord1[7:0]) && !$past(outWord1[14]);
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("command code mismatch");

  property p_cmd_payload;
    cmdValid |-> cmdPayload == $past({outWord8, outWord7, outWord6, outWord5, outWord4,
                                      outWord3, outWord2});
  endproperty
  a_cmd_payload: assert property (p_cmd_payload) else $error("payload mismatch");

  property p_run;
    1'b1 |=> pulseEnable == $past(outWord1[13]);
  endproperty
  a_run: assert property (p_run) else $error("pulse enable does not follow run");

  property p_sticky;
    $fell(inWord1[11]) || $fell(inWord1[8]) |->
      ($past(outWord1[7:0], 2) inside {8'h01, 8'h03}) ||
      ($past(outWord1[7:0], 3) inside {8'h01, 8'h03});
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault dropped without clear");

  property p_fault_set;
    faultEventA |-> ##[1:2] inWord1[11];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("axis fault not shown");

  property p_sys_fault;
    sysFaultEvent |-> ##[1:2] !inWord1[14];
  endproperty
  a_sys_fault: assert property (p_sys_fault) else $error("module ok still set");

  property p_status_map;
    1'b1 |=> inWord1[7:0] == $past(systemByte) && {inWord1[13:12], inWord1[10:9]} ==
      $past({axisPulsingA, axisStandbyA, axisPulsingB, axisStandbyB});
  endproperty
  a_status_map: assert property (p_status_map) else $error("status word layout");
endmodule // mwx_host_exchange_properties

bind mwx_host_exchange mwx_host_exchange_properties u_props (
  .clock(clock), .reset(reset), .outWord1(outWord1), .outWord2(outWord2),
  .outWord3(outWord3), .outWord4(outWord4), .outWord5(outWord5), .outWord6(outWord6),
  .outWord7(outWord7), .outWord8(outWord8), .axisPulsingA(axisPulsingA),
  .axisStandbyA(axisStandbyA), .axisPulsingB(axisPulsingB), .axisStandbyB(axisStandbyB),
  .faultEventA(faultEventA), .sysFaultEvent(sysFaultEvent), .systemByte(systemByte),
  .inWord1(inWord1), .pulseEnable(pulseEnable), .cmdValid(cmdValid), .cmdCode(cmdCode),
  .cmdPayload(cmdPayload));

// *** testbench/mwx_ctrl_model.sv ***
module mwx_ctrl_model (
  input  wire logic             clock,
  input  wire logic [15:0]      inWord1,
  output logic      [8:1][15:0] outWords
);
  timeunit 1ns;
  timeprecision 100ps;

  initial outWords = {8{16'h0000}};

  // ****************************************
  // controller scan actions
  // ****************************************
  // one command per toggle flip; words stay put until the echo matches
  task automatic send(input logic [7:0] code, input logic [1:0] axis,
                      input logic [6:0][15:0] data);
    int n;
    @(posedge clock);
    #2;
    outWords[8:2] = data;
    outWords[1][9:0] = {axis, code};
    outWords[1][15] = !outWords[1][15];
    n = 0;
    while (inWord1[15] !== outWords[1][15] && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (n == 400) testbench.num_errors++;
    #2;
  endtask

  // toggle dropped while restart is high must be ignored
  task automatic restart();
    @(posedge clock);
    #2 outWords[1][14] = 1'b1;
    @(posedge clock);
    #2 outWords[1][15] = 1'b0;
    @(posedge clock);
    #2 outWords[1][14] = 1'b0;
    repeat (3) @(posedge clock);
    #2;
  endtask

  task automatic set_run(input logic run);
    @(posedge clock);
    #2 outWords[1][13] = run;
  endtask
endmodule // mwx_ctrl_model

// *** testbench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic             clock;
  logic             reset;
  wire  [8:1][15:0] outW;
  wire  [15:0]      inW [1:8];
  logic             pulA, stbA, pulB, stbB, fltA, fltB, fltSys, ready, serial, done, more;
  logic             loadValid, pulseEnable, cmdValid, cmdContinue;
  logic [7:0]       sysByte, cmdCode, expCode;
  logic [1:0]       kind, cmdAxis, expAxis;
  logic [4:0]       lenA, lenB, loadAddr;
  logic [15:0]      extIn, errA, errB, loadData;
  logic [5:0][15:0] defaults;
  logic [6:0][15:0] payload, data;
  logic [15:0]      mem [0:31];
  logic [1:0]       axisSeen [$];
  logic [31:0]      seed = 32'h1528AFFF;
  int               num_errors, n_compared, cycles, n;

  mwx_host_exchange uut (
    .clock(clock), .reset(reset), .outWord1(outW[1]), .outWord2(outW[2]), .outWord3(outW[3]),
    .outWord4(outW[4]), .outWord5(outW[5]), .outWord6(outW[6]), .outWord7(outW[7]),
    .outWord8(outW[8]), .axisPulsingA(pulA), .axisStandbyA(stbA), .axisPulsingB(pulB),
    .axisStandbyB(stbB), .faultEventA(fltA), .faultEventB(fltB), .sysFaultEvent(fltSys),
    .moduleReady(ready), .systemByte(sysByte), .extInputs(extIn), .defaultWords(defaults),
    .cmdSerial(serial), .cmdDone(done), .cmdMore(more), .respKind(kind), .respLenA(lenA),
    .respLenB(lenB), .errCodeA(errA), .errCodeB(errB), .loadValid(loadValid),
    .loadAddr(loadAddr), .loadData(loadData), .inWord1(inW[1]), .inWord2(inW[2]),
    .inWord3(inW[3]), .inWord4(inW[4]), .inWord5(inW[5]), .inWord6(inW[6]), .inWord7(inW[7]),
    .inWord8(inW[8]), .pulseEnable(pulseEnable), .cmdValid(cmdValid),
    .cmdContinue(cmdContinue), .cmdCode(cmdCode), .cmdAxis(cmdAxis), .cmdPayload(payload));
  mwx_ctrl_model ctrl (.clock(clock), .inWord1(inW[1]), .outWords(outW));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_word1(input logic ok, input logic fa, input logic fb);
    return {outW[1][15], ok, pulA, stbA, fa, pulB, stbB, fb, sysByte};
  endfunction

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    check_word(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic check_cmd(input logic fa, input logic fb);
    check_word("code", {8'h00, expCode}, {8'h00, cmdCode});
    check_word("axis", {14'h0000, expAxis}, {14'h0000, cmdAxis});
    for (int i = 0; i < 7; i++) check_word("payload", data[i], payload[i]);
    check_word("status", exp_word1(1'b1, fa, fb), inW[1]);
    check_flag("run", outW[1][13], pulseEnable);
    check_word("word2", extIn, inW[2]);
    check_flag("continue", 1'b0, cmdContinue);
  endtask

  task automatic read_check(input logic [7:0] code, input logic [1:0] axis,
                            input logic [3:0][15:0] exp);
    ctrl.send(code, axis, data);
    check_word("errA", errA, inW[3]);
    check_word("errB", errB, inW[4]);
    for (int i = 0; i < 4; i++) check_word("resp", exp[i], inW[i + 5]);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // clock, engine stand-in, watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end

  // answers every issued command two cycles later
  always @(posedge clock) begin
    if (cmdValid === 1'b1) begin
      axisSeen.push_back(cmdAxis);
      repeat (2) @(posedge clock);
      #2 done = 1'b1;
      @(posedge clock);
      #2 done = 1'b0;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    {pulA, stbA, pulB, stbB, fltA, fltB, fltSys, serial, done, more, loadValid} = 11'h000;
    {ready, kind, lenA, lenB, loadAddr, loadData} = 34'h200000000;
    {sysByte, extIn, errA, errB} = 56'({rnd(), rnd()});
    defaults = {rnd(), rnd(), rnd()};
    repeat (16) @(posedge clock);
    #2 reset = 1'b0;
    repeat (2) @(posedge clock);
    #2;
    for (int i = 0; i < 6; i++) check_word("default", defaults[i], inW[i + 3]);
    for (int k = 0; k < 8; k++) begin
      {pulA, stbA, pulB, stbB} = 4'(rnd());
      sysByte = 8'(rnd());
      data = {rnd(), rnd(), rnd(), 16'(rnd())};
      expCode = 8'h10 | 8'(rnd() & 32'h0000000F);
      expAxis = 2'(rnd() % 3 + 1);
      ctrl.set_run(1'(rnd()));
      ctrl.send(expCode, expAxis, data);
      check_cmd(1'b0, 1'b0);
    end
    {fltA, fltB} = 2'h3;
    @(posedge clock);
    #2 {fltA, fltB} = 2'h0;
    more = 1'b1;
    ctrl.send(expCode, expAxis, data);
    check_cmd(1'b1, 1'b1);
    more = 1'b0;
    ctrl.send(mwx_pkg::CMD_CLEAR_ALL, mwx_pkg::AXIS_BOTH, data);
    check_flag("continue", 1'b1, cmdContinue);
    check_word("clearSkip", exp_word1(1'b1, 1'b1, 1'b1), inW[1]);
    ctrl.send(mwx_pkg::CMD_CLEAR_AXIS, mwx_pkg::AXIS_A, data);
    check_word("clearAxis", exp_word1(1'b1, 1'b0, 1'b1), inW[1]);
    fltSys = 1'b1;
    @(posedge clock);
    #2 fltSys = 1'b0;
    repeat (3) @(posedge clock);
    #2 check_word("sysFault", exp_word1(1'b0, 1'b0, 1'b1), inW[1]);
    ctrl.send(mwx_pkg::CMD_CLEAR_SYSTEM, mwx_pkg::AXIS_A, data);
    check_word("clearSys", exp_word1(1'b1, 1'b0, 1'b1), inW[1]);
    ctrl.send(mwx_pkg::CMD_CLEAR_ALL, mwx_pkg::AXIS_BOTH, data);
    check_word("clearAll", exp_word1(1'b1, 1'b0, 1'b0), inW[1]);
    loadValid = 1'b1;
    for (int a = 0; a < 18; a++) begin
      if (a < 9 || a > 15) begin
        mem[a] = 16'(rnd());
        {loadAddr, loadData} = {5'(a), mem[a]};
        @(posedge clock);
        #2;
      end
    end
    loadValid = 1'b0;
    {kind, lenA, lenB} = {2'h1, 5'h02, 5'h02};
    read_check(8'h20, mwx_pkg::AXIS_BOTH, {mem[17], mem[16], mem[1], mem[0]});
    kind = 2'h2;
    read_check(8'hA0, mwx_pkg::AXIS_BOTH, {mem[1], mem[0], mem[17], mem[16]});
    {kind, lenA, lenB} = {2'h3, 5'h09, 5'h00};
    read_check(8'hB0, 2'h0, {mem[2], mem[1], mem[0], 16'h0009});
    read_check(8'hB0, 2'h0, {mem[6], mem[5], mem[4], mem[3]});
    read_check(8'hB0, 2'h0, {32'h00000000, mem[8], mem[7]});
    {serial, kind} = 3'h4;
    n = axisSeen.size();
    ctrl.send(8'h30, mwx_pkg::AXIS_BOTH, data);
    check_word("serialCount", 16'(n + 2), 16'(axisSeen.size()));
    check_word("firstAxis", {14'h0000, mwx_pkg::AXIS_A}, {14'h0000, axisSeen[n]});
    check_word("secondAxis", {14'h0000, mwx_pkg::AXIS_B}, {14'h0000, axisSeen[n + 1]});
    serial = 1'b0;
    n = axisSeen.size();
    ctrl.restart();
    check_flag("restartEcho", 1'b0, inW[1][15]);
    check_word("restartQuiet", 16'(n), 16'(axisSeen.size()));
    {expCode, expAxis} = {8'h18, mwx_pkg::AXIS_B};
    ctrl.send(expCode, expAxis, data);
    check_cmd(1'b0, 1'b0);
    final_report();
  end
endmodule // testbench
